// ==== include/bbc_consts.vh ====
`ifndef BBC_CONSTS_VH
`define BBC_CONSTS_VH
// ==========================================
// Register indices (printed offsets, byte address = 4 * index)
`define BBC_IDX_CTRL0    12'h100
`define BBC_IDX_CTRL1    12'h101
`define BBC_IDX_ROP      12'h102
`define BBC_IDX_OPSEL    12'h103
`define BBC_IDX_LAST     12'h119
`define BBC_IDX_DATA     12'h110
`define BBC_IDX_IRQ_STAT 12'h118
`define BBC_IDX_IRQ_MASK 12'h119
// ==========================================
// Control register 0 field positions
`define BBC_C0_RUN       7
`define BBC_C0_NEMPTY    6
`define BBC_C0_HALF      5
`define BBC_C0_FULL      4
`define BBC_C0_DLIN      1
`define BBC_C0_SLIN      0
// Control register 1 field positions
`define BBC_C1_RSVD      4
`define BBC_C1_DEPTH     0
// ==========================================
// FIFO geometry and thresholds
`define BBC_FIFO_DEPTH   16
`define BBC_FIFO_HALF    8
// Operation codes
`define BBC_OP_WRITE     4'h0
`define BBC_OP_READ      4'h1
`define BBC_OP_MOVE_POS  4'h2
`define BBC_OP_MOVE_NEG  4'h3
`define BBC_OP_TR_WRITE  4'h4
`define BBC_OP_TR_MOVE   4'h5
`define BBC_OP_PAT       4'h6
`define BBC_OP_PAT_TR    4'h7
`define BBC_OP_CEXP      4'h8
`define BBC_OP_CEXP_TR   4'h9
`define BBC_OP_MCEXP     4'hA
`define BBC_OP_MCEXP_TR  4'hB
`define BBC_OP_SOLID     4'hC
// Interrupt bit positions
`define BBC_IRQ_DONE     0
`define BBC_IRQ_FULL     1
// Reset values
`define BBC_RST_BYTE     8'h00
`endif

// ==== hdl/bbc_rop.v ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Four-bit raster op: code bits form the truth table of (s,d)
module bbc_rop #(
	parameter W = 16
) (
	input  wire [3:0]   i_code,
	input  wire [W-1:0] i_s,
	input  wire [W-1:0] i_d,
	output wire [W-1:0] o_res
);
	// Bit index {s,d}: code[0]=~s~d, code[1]=~s d, code[2]=s~d, code[3]=s d
	assign o_res = ({W{i_code[0]}} & ~i_s & ~i_d)
		| ({W{i_code[1]}} & ~i_s & i_d)
		| ({W{i_code[2]}} & i_s & ~i_d)
		| ({W{i_code[3]}} & i_s & i_d);
endmodule
`default_nettype wire

// ==== hdl/bbc_fifo.v ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Host data FIFO with occupancy count
module bbc_fifo #(
	parameter W  = 16,
	parameter D  = 16,
	parameter AW = 4
) (
	input  wire          i_ref_clk,
	input  wire          i_rst_n,
	input  wire          i_ce,
	input  wire          i_push,
	input  wire [W-1:0]  i_wdata,
	input  wire          i_pop,
	output wire [W-1:0]  o_rdata,
	output wire [AW:0]   o_count
);
	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wp_q;
	reg [AW-1:0] rp_q;
	reg [AW:0]   cnt_q;
	wire         do_push;
	wire         do_pop;

	// Refuse push when full, pop when empty
	// Compare at full width; a part-select of an untyped parameter is not portable
	assign do_push = i_push && (cnt_q < D);
	assign do_pop  = i_pop && (cnt_q != {(AW+1){1'b0}});
	assign o_rdata = mem[rp_q];
	assign o_count = cnt_q;

	// Storage array, no reset needed
	always @(posedge i_ref_clk) begin
		if (i_ce && do_push) begin
			mem[wp_q] <= i_wdata;
		end
	end

	// Pointers and count
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			wp_q  <= {AW{1'b0}};
			rp_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else if (i_ce) begin
			if (do_push) begin
				wp_q <= wp_q + 1'b1;
			end
			if (do_pop) begin
				rp_q <= rp_q + 1'b1;
			end
			if (do_push && !do_pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (do_pop && !do_push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== hdl/bbc_top.v ====
// Contract
// - Writing one to run bit launches operation
// - Run bit reads 1 busy, 0 idle
// - Not-empty flag set when FIFO nonempty
// - Half flag set at 8 or more
// - Sixteen-deep FIFO, full flag at 16
// - Destination linear bit selects addressing mode
// - Source linear bit selects fetch mode
// - Depth bit selects 8 or 16 bpp; solid fill ignores it and writes the whole word
// - All sixteen two-operand raster ops
// - Result from source, pattern, destination
// - Writes display buffer; source buffer/pattern/host
// - Registers decoded within 100h through 119h
// - ROP code selects function or start bit
// - Operation codes 0 to 12, rest reserved
//
// Register access over APB was decided locally.
`include "bbc_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module bbc_top #(
	parameter AW = 24
) (
	input  wire          i_ref_clk,
	input  wire          i_rst_n,
	input  wire          i_ce,
	// APB slave
	input  wire          i_psel,
	input  wire          i_penable,
	input  wire          i_pwrite,
	input  wire [13:0]   i_paddr,
	input  wire [31:0]   i_pwdata,
	output wire          o_pready,
	output reg  [31:0]   o_prdata,
	output wire          o_pslverr,
	// Transfer geometry from the address/size registers outside
	input  wire [AW-1:0] i_src_addr,
	input  wire [AW-1:0] i_dst_addr,
	input  wire [AW-1:0] i_pat_addr,
	input  wire [11:0]   i_width,
	input  wire [11:0]   i_height,
	input  wire [AW-1:0] i_stride,
	// Display memory port
	output reg           o_mem_req,
	output reg           o_mem_we,
	output reg  [AW-1:0] o_mem_addr,
	output reg  [15:0]   o_mem_wdata,
	input  wire          i_mem_ack,
	input  wire [15:0]   i_mem_rdata,
	output wire          o_irq
);
	// ==========================================
	// State encoding
	localparam [4:0] ST_IDLE = 5'b00001;
	localparam [4:0] ST_SRC  = 5'b00010;
	localparam [4:0] ST_DST  = 5'b00100;
	localparam [4:0] ST_WR   = 5'b01000;
	localparam [4:0] ST_NEXT = 5'b10000;

	reg [4:0]    state_q;
	reg [4:0]    state_d;
	reg          dlin_q;
	reg          slin_q;
	reg          depth_q;
	reg [3:0]    rop_q;
	reg [3:0]    op_q;
	reg [1:0]    irq_stat_q;
	reg [1:0]    irq_mask_q;
	reg [11:0]   x_q;
	reg [11:0]   y_q;
	reg [AW-1:0] s_off_q;
	reg [AW-1:0] d_off_q;
	reg [15:0]   s_q;
	reg [15:0]   d_q;
	wire [4:0]   fifo_cnt;
	wire [15:0]  fifo_rdata;
	wire [15:0]  rop_res;
	wire [15:0]  res_pix;
	wire [15:0]  op_a;
	wire [15:0]  cexp_pix;
	wire         busy;
	wire         wr_acc;
	wire         rd_acc;
	wire         in_range;
	wire [11:0]  idx;
	wire         f_nempty;
	wire         f_half;
	wire         f_full;
	wire         launch;
	wire         last_pix;
	wire         host_src;
	wire         pat_src;
	wire         op_valid;
	wire         fifo_push;
	wire         fifo_pop;
	wire         done_ev;
	wire [7:0]   ctrl0_rd;
	wire [2:0]   cexp_bit;
	wire [AW-1:0] s_addr;
	wire [AW-1:0] d_addr;

	// ==========================================
	// APB decode, zero wait states
	assign idx       = i_paddr[13:2];
	assign in_range  = (idx >= `BBC_IDX_CTRL0) && (idx <= `BBC_IDX_LAST);
	assign wr_acc    = i_psel && i_penable && i_pwrite && i_ce;
	assign rd_acc    = i_psel && !i_penable && !i_pwrite;
	assign o_pready  = 1'b1;
	assign o_pslverr = i_psel && i_penable && !in_range;

	// Status flags straight from FIFO occupancy; busy from engine state
	assign f_nempty = (fifo_cnt != 5'h00);
	assign f_half   = (fifo_cnt >= `BBC_FIFO_HALF);
	assign f_full   = (fifo_cnt == `BBC_FIFO_DEPTH);
	assign busy     = (state_q != ST_IDLE);
	assign ctrl0_rd = {busy, f_nempty, f_half, f_full, 2'b00, dlin_q, slin_q};

	// Reserved codes are ignored so the engine never hangs
	assign op_valid = (i_pwdata[3:0] <= `BBC_OP_SOLID);
	assign launch   = wr_acc && (idx == `BBC_IDX_CTRL0) && i_pwdata[`BBC_C0_RUN]
		&& !busy && (op_q <= `BBC_OP_SOLID);
	// Host data pushed while full is dropped; software polls the full flag
	assign fifo_push = wr_acc && (idx == `BBC_IDX_DATA);

	// ==========================================
	// Register writes
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			dlin_q     <= 1'b0;
			slin_q     <= 1'b0;
			depth_q    <= 1'b0;
			rop_q      <= 4'h0;
			op_q       <= 4'h0;
			irq_mask_q <= 2'b00;
		end else if (wr_acc) begin
			case (idx)
				`BBC_IDX_CTRL0: begin
					dlin_q <= i_pwdata[`BBC_C0_DLIN];
					slin_q <= i_pwdata[`BBC_C0_SLIN];
				end
				// Reserved bit is not stored; software keeps it zero
				`BBC_IDX_CTRL1: depth_q <= i_pwdata[`BBC_C1_DEPTH];
				`BBC_IDX_ROP: rop_q <= i_pwdata[3:0];
				`BBC_IDX_OPSEL: begin
					if (op_valid) begin
						op_q <= i_pwdata[3:0];
					end
				end
				`BBC_IDX_IRQ_MASK: irq_mask_q <= i_pwdata[1:0];
				default: ;
			endcase
		end
	end

	// Read mux, registered in setup phase
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_prdata <= 32'h00000000;
		end else if (rd_acc && i_ce) begin
			case (idx)
				`BBC_IDX_CTRL0:    o_prdata <= {24'h000000, ctrl0_rd};
				`BBC_IDX_CTRL1:    o_prdata <= {31'h00000000, depth_q};
				`BBC_IDX_ROP:      o_prdata <= {28'h0000000, rop_q};
				`BBC_IDX_OPSEL:    o_prdata <= {28'h0000000, op_q};
				`BBC_IDX_DATA:     o_prdata <= {16'h0000, fifo_rdata};
				`BBC_IDX_IRQ_STAT: o_prdata <= {30'h00000000, irq_stat_q};
				`BBC_IDX_IRQ_MASK: o_prdata <= {30'h00000000, irq_mask_q};
				default:           o_prdata <= 32'h00000000;
			endcase
		end
	end

	// ==========================================
	// Sticky interrupts; a new event wins over the write-one clear
	assign done_ev = (state_q == ST_NEXT) && last_pix;
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			irq_stat_q <= 2'b00;
		end else if (i_ce) begin
			irq_stat_q <= (irq_stat_q & ~((wr_acc && idx == `BBC_IDX_IRQ_STAT) ?
				i_pwdata[1:0] : 2'b00)) | {f_full, done_ev};
		end
	end
	assign o_irq = |(irq_stat_q & irq_mask_q);

	// ==========================================
	// Operand sourcing and addressing
	assign host_src = (op_q == `BBC_OP_WRITE) || (op_q == `BBC_OP_TR_WRITE)
		|| (op_q == `BBC_OP_CEXP) || (op_q == `BBC_OP_CEXP_TR);
	assign pat_src  = (op_q == `BBC_OP_PAT) || (op_q == `BBC_OP_PAT_TR);
	assign fifo_pop = (state_q == ST_SRC) && host_src && f_nempty && i_ce;
	// Linear blocks step contiguously; rectangles add the stride per line
	assign s_addr = (slin_q ? s_off_q : s_off_q + i_stride * y_q)
		+ (pat_src ? i_pat_addr : i_src_addr);
	assign d_addr = (dlin_q ? d_off_q : d_off_q + i_stride * y_q) + i_dst_addr;
	assign last_pix = (x_q == i_width - 12'h001) && (y_q == i_height - 12'h001);

	// Colour expansion: start bit from ROP modulo eight
	assign cexp_bit = rop_q[2:0] + x_q[2:0];
	assign cexp_pix = s_q[cexp_bit] ? 16'hFFFF : 16'h0000;
	// Move ops use source; pattern fill uses pattern in the source slot
	assign op_a = (op_q >= `BBC_OP_CEXP && op_q <= `BBC_OP_MCEXP_TR) ? cexp_pix : s_q;
	bbc_rop #(
		.W(16)
	) u_rop (
		.i_code(rop_q),
		.i_s   (op_a),
		.i_d   (d_q),
		.o_res (rop_res)
	);
	// 8 bpp only touches the low byte, except solid fill, which writes the whole word
	assign res_pix = (op_q == `BBC_OP_SOLID) ? s_q :
		(depth_q ? rop_res : {d_q[15:8], rop_res[7:0]});

	bbc_fifo #(
		.W (16),
		.D (`BBC_FIFO_DEPTH),
		.AW(4)
	) u_fifo (
		.i_ref_clk(i_ref_clk),
		.i_rst_n  (i_rst_n),
		.i_ce     (i_ce),
		.i_push   (fifo_push),
		.i_wdata  (i_pwdata[15:0]),
		.i_pop    (fifo_pop),
		.o_rdata  (fifo_rdata),
		.o_count  (fifo_cnt)
	);

	// ==========================================
	// Engine next-state
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: if (launch) state_d = ST_SRC;
			ST_SRC: begin
				if (host_src ? f_nempty : (op_q == `BBC_OP_SOLID || i_mem_ack)) begin
					state_d = ST_DST;
				end
			end
			ST_DST:  if (i_mem_ack) state_d = ST_WR;
			ST_WR:   if (i_mem_ack) state_d = ST_NEXT;
			// Busy drops only after the final destination write
			ST_NEXT: state_d = last_pix ? ST_IDLE : ST_SRC;
			default: state_d = ST_IDLE;
		endcase
	end

	// Engine datapath and memory port
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			state_q     <= ST_IDLE;
			x_q         <= 12'h000;
			y_q         <= 12'h000;
			s_off_q     <= {AW{1'b0}};
			d_off_q     <= {AW{1'b0}};
			s_q         <= 16'h0000;
			d_q         <= 16'h0000;
			o_mem_req   <= 1'b0;
			o_mem_we    <= 1'b0;
			o_mem_addr  <= {AW{1'b0}};
			o_mem_wdata <= 16'h0000;
		end else if (i_ce) begin
			state_q   <= state_d;
			o_mem_req <= 1'b0;
			o_mem_we  <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					x_q     <= 12'h000;
					y_q     <= 12'h000;
					s_off_q <= {AW{1'b0}};
					d_off_q <= {AW{1'b0}};
				end
				ST_SRC: begin
					if (host_src) begin
						s_q <= fifo_rdata;
					end else if (op_q == `BBC_OP_SOLID) begin
						s_q <= {rop_q, rop_q, rop_q, rop_q};
					end else if (i_mem_ack) begin
						s_q <= i_mem_rdata;
					end else begin
						o_mem_req  <= 1'b1;
						o_mem_addr <= s_addr;
					end
				end
				ST_DST: begin
					if (i_mem_ack) begin
						d_q <= i_mem_rdata;
					end else begin
						o_mem_req  <= 1'b1;
						o_mem_addr <= d_addr;
					end
				end
				ST_WR: begin
					if (!i_mem_ack) begin
						o_mem_req   <= 1'b1;
						o_mem_we    <= 1'b1;
						o_mem_addr  <= d_addr;
						o_mem_wdata <= res_pix;
					end
				end
				ST_NEXT: begin
					s_off_q <= s_off_q + 1'b1;
					d_off_q <= d_off_q + 1'b1;
					if (x_q == i_width - 12'h001) begin
						x_q <= 12'h000;
						y_q <= y_q + 12'h001;
						if (!slin_q) s_off_q <= {AW{1'b0}};
						if (!dlin_q) d_off_q <= {AW{1'b0}};
					end else begin
						x_q <= x_q + 12'h001;
					end
				end
				default: ;
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== dv/bbc_top_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Port-level checks of the blit front end
module bbc_chk #(
	parameter AW = 24
) (
	input wire logic          i_ref_clk,
	input wire logic          i_rst_n,
	input wire logic          i_ce,
	input wire logic          i_psel,
	input wire logic          i_penable,
	input wire logic          i_pwrite,
	input wire logic [13:0]   i_paddr,
	input wire logic [31:0]   i_pwdata,
	input wire logic          o_pready,
	input wire logic [31:0]   o_prdata,
	input wire logic          o_pslverr,
	input wire logic          o_mem_req,
	input wire logic [AW-1:0] o_mem_addr,
	input wire logic          i_mem_ack,
	input wire logic          o_irq
);
	// Decode helpers
	wire        acc = i_psel && i_penable;
	wire [11:0] ix  = i_paddr[13:2];
	wire        oob = (ix < 12'h100) || (ix > 12'h119);
	wire        rds = i_ce && i_psel && !i_penable && !i_pwrite;
	wire        mk0 = acc && i_pwrite && i_ce && ix == 12'h119 && i_pwdata[1:0] == 2'b00;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// ==========================================
	// Bus answer and decode
	chk_ready_high: assert property (o_pready)
		else $error("pready low");
	chk_err_out: assert property (acc && oob |-> o_pslverr)
		else $error("no error outside map");
	chk_err_in: assert property (acc && !oob |-> !o_pslverr)
		else $error("error inside map");
	chk_oob_zero: assert property (rds && oob |=> o_prdata == 32'h0)
		else $error("unmapped read not zero");
	// Read data stands between setups; hold freezes the memory request and address
	chk_rd_hold: assert property (!(i_psel && !i_penable) |=> $stable(o_prdata))
		else $error("read data moved");
	chk_ce_freeze: assert property (!i_ce |=> $stable(o_mem_req) && $stable(o_mem_addr))
		else $error("state moved while frozen");
	// Memory request retried unchanged until acknowledged
	chk_req_hold: assert property (i_ce && o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
		else $error("request dropped before ack");
	chk_irq_mask: assert property (mk0 |=> !o_irq)
		else $error("masked interrupt high");
endmodule
bind bbc_top bbc_chk #(.AW(AW)) bbc_chk_inst (.i_ref_clk, .i_rst_n, .i_ce, .i_psel,
	.i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_prdata, .o_pslverr,
	.o_mem_req, .o_mem_addr, .i_mem_ack, .o_irq);
`default_nettype wire

// ==== dv/bbc_mem_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Display memory: random stall, destination word is ~address
module bbc_mem_model #(
	parameter AW = 24
) (
	input  wire logic          i_ref_clk,
	input  wire logic          i_rst_n,
	input  wire logic          i_req,
	input  wire logic [AW-1:0] i_addr,
	output logic               o_ack,
	output logic [15:0]        o_rdata
);
	int wt_q;
	// Data line toggles outside the ack so stale data never matches
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_ack <= 1'b0;
			wt_q <= 0;
			o_rdata <= 16'h0;
		end else if (o_ack) begin
			o_ack <= 1'b0;
			o_rdata <= ~o_rdata;
			wt_q <= $urandom_range(5);
		end else if (i_req && wt_q == 0) begin
			o_ack <= 1'b1;
			o_rdata <= ~i_addr[15:0];
		end else begin
			if (i_req) wt_q <= wt_q - 1;
			o_rdata <= ~o_rdata;
		end
	end
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
`include "bbc_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic i_ref_clk, i_rst_n, i_ce, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
	logic [13:0] i_paddr;
	logic [31:0] i_pwdata, o_prdata, last;
	logic [23:0] i_src_addr, i_dst_addr, i_pat_addr, i_stride;
	logic [11:0] i_width, i_height;
	logic o_mem_req, o_mem_we, i_mem_ack, o_irq;
	logic [23:0] o_mem_addr;
	logic [15:0] o_mem_wdata, i_mem_rdata;
	logic [63:0] rq[$];
	logic [39:0] wq[$];
	logic [15:0] sq[$];
	logic [31:0] d;
	logic [31:0] rm;
	int n_fail, check_count, k, j;
	bbc_top bbc_top_inst (.*);
	bbc_mem_model bbc_mem_model_inst (.i_ref_clk, .i_rst_n, .i_req(o_mem_req),
		.i_addr(o_mem_addr), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
	// ==========================================
	// Clock and hang guard
	always #2.5 i_ref_clk = ~i_ref_clk;
	initial begin
		#250000;
		n_fail++;
		test_done;
	end
	task automatic cmp(input logic [63:0] g, input logic [63:0] e);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task test_done;
		if (n_fail == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// APB master, one idle cycle between transfers
	task automatic apb(input logic [11:0] ix, input logic w, input logic [31:0] v);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= {ix, 2'b00};
		i_pwdata <= v;
		@(posedge i_ref_clk) i_penable <= 1'b1;
		do @(posedge i_ref_clk); while (o_pready !== 1'b1);
		last = o_prdata;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_ref_clk);
	endtask
	task automatic rx(input logic [11:0] ix, input logic [31:0] e, input logic [31:0] m);
		rq.push_back({m, e});
		apb(ix, 1'b0, 32'h0);
	endtask
	function automatic logic [15:0] rop(input logic [3:0] c, input logic [15:0] s, d);
		return ({16{c[3]}} & s & d) | ({16{c[2]}} & s & ~d) | ({16{c[1]}} & ~s & d)
			| ({16{c[0]}} & ~s & ~d);
	endfunction
	// Note every write of a run, launch it, then poll until idle
	task automatic blit(input logic [3:0] c, input logic [1:0] md, input int w, h);
		logic [23:0] a;
		logic [15:0] v, dv;
		int n;
		i_width <= w;
		i_height <= h;
		apb(`BBC_IDX_CTRL1, 1'b1, md[1]);
		apb(`BBC_IDX_ROP, 1'b1, c);
		for (int y = 0; y < h; y++) for (int x = 0; x < w; x++) begin
			a = i_dst_addr + (md[0] ? y * w : y * i_stride) + x;
			dv = ~a[15:0];
			v = rop(c, sq.pop_front(), dv);
			wq.push_back({a, md[1] ? v : {dv[15:8], v[7:0]}});
		end
		apb(`BBC_IDX_CTRL0, 1'b1, 8'h80 | {md[0], md[0]});
		rx(`BBC_IDX_CTRL0, 32'h80, 32'h80);
		i_ce <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
		i_ce <= 1'b1;
		n = 0;
		do begin
			rx(`BBC_IDX_CTRL0, 32'h0, 32'h0);
			n++;
		end while (last[7] !== 1'b0 && n < 300);
		rx(`BBC_IDX_CTRL0, 32'h0, 32'hF0);
	endtask
	// Scoreboard: oldest note against each read and memory write
	always @(posedge i_ref_clk) begin
		if (i_psel && i_penable && !i_pwrite && o_pready) begin
			// Own mask variable so stimulus data in d is never overwritten
			rm = rq[0][63:32];
			cmp(o_prdata & rm, rq.pop_front() & rm);
		end
		if (i_ce && o_mem_req && o_mem_we && i_mem_ack) begin
			cmp({o_mem_addr, o_mem_wdata}, wq.pop_front());
		end
	end
	// ==========================================
	// Main sequence
	initial begin
		{i_ref_clk, i_rst_n, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = 0;
		{n_fail, check_count} = 0;
		{i_ce, i_width, i_height} = {1'b1, 24'h001001};
		{i_src_addr, i_pat_addr, i_dst_addr, i_stride} = {24'h2000, 24'h3000, 24'h1000, 24'h8};
		d = $urandom(41);
		repeat (10) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		rx(`BBC_IDX_CTRL0, 32'h0, 32'hFFFFFFFF);
		rx(`BBC_IDX_CTRL1, 32'h0, 32'hFFFFFFFF);
		rx(12'h0FF, 32'h0, 32'hFFFFFFFF);
		rx(12'h11A, 32'h0, 32'hFFFFFFFF);
		for (k = 0; k < 16; k++) begin
			apb(`BBC_IDX_OPSEL, 1'b1, k);
			rx(`BBC_IDX_OPSEL, k > 12 ? 12 : k, 32'hF);
		end
		apb(`BBC_IDX_OPSEL, 1'b1, `BBC_OP_WRITE);
		for (k = 1; k <= 17; k++) begin
			d = $urandom;
			apb(`BBC_IDX_DATA, 1'b1, d);
			if (k <= 16) sq.push_back(d[15:0]);
			j = k > 16 ? 16 : k;
			rx(`BBC_IDX_CTRL0, {j >= 1, j >= 8, j == 16, 4'h0}, 32'hF0);
		end
		blit(4'hC, 2'b10, 4, 4);
		rx(`BBC_IDX_IRQ_STAT, 32'h3, 32'h3);
		apb(`BBC_IDX_IRQ_MASK, 1'b1, 32'h1);
		cmp(o_irq, 1'b1);
		apb(`BBC_IDX_IRQ_STAT, 1'b1, 32'h3);
		cmp(o_irq, 1'b0);
		apb(`BBC_IDX_IRQ_MASK, 1'b1, 32'h0);
		for (k = 0; k < 16; k++) begin
			for (j = 0; j < 4; j++) begin
				d = $urandom;
				apb(`BBC_IDX_DATA, 1'b1, d);
				sq.push_back(d[15:0]);
			end
			blit(k, k[1:0], 2, 2);
		end
		cmp(wq.size(), 0);
		test_done;
	end
endmodule
`default_nettype wire
